// ===== hdl/vipc_top.sv
// Vectored interrupt controller: flags, enables, priorities, vector output.
// Assumes sources and the core run on core_clk; Avalon-MM slave for registers.
//
// Summary of operation
// - Vector entry equals programmable spacing register times number
// - Sources 0..22 use flag/enable bit n
// - Core timer 0, software 1-2, pins 3-7
// - Four groups per priority register, v/4
// - Sources 16,17,20,21,22 are persistent
// - Priority field 1..7, zero disables source
// - Subpriority field 0..3 orders equal priority
// - Unused priority bits read zero, ignore writes
`timescale 1ns/1ns
`include "vipc_regs.svh"
module vipc_top
  import vipc_pkg::*;
#(
  parameter int NSRC = `VIPC_NUM_SRC,
  parameter int NREG = `VIPC_NUM_PRIO_REGS
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Avalon-MM slave
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  output logic [1:0]            avs_response,
  // Interrupt sources: pulse events and persistent levels
  input  wire logic [NSRC-1:0]  src_event,
  // Core side
  output logic                  irq_req_r,
  output logic [4:0]            irq_vector_r,
  output logic [2:0]            irq_level_r,
  output logic [31:0]           irq_entry_r,
  output logic                  irq_out_r
);
  // Refuse counts that the decode cannot serve
  if (NSRC < 1 || NSRC > 32 || NREG * 4 < NSRC) begin : g_bad_cfg
    $error("vipc_top: unsupported source or register count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [NSRC-1:0]  flag_r;
  logic [NSRC-1:0]  enable_r;
  logic [15:0]      vspace_r;
  logic [1:0]       status_r;
  logic [1:0]       mask_r;
  logic [NREG*32-1:0] prio_flat;
  logic [31:0]      prio_rdata;
  vipc_bus_state_t  bus_st_r;
  logic [31:0]      rd_mux_r;
  logic             rd_prio_r;

  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit
  wire logic [7:0] prio_ofs  = avs_address - `VIPC_OFS_PRIO_BASE;
  wire logic       is_prio   = avs_address >= `VIPC_OFS_PRIO_BASE &&
                               prio_ofs < 8'(NREG * 4) && avs_address[1:0] == 2'b00;
  wire logic       wr_go     = avs_write && bus_st_r == VIPC_S_IDLE;
  wire logic       rd_go     = avs_read && bus_st_r == VIPC_S_IDLE;
  wire logic [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [31:0] wd       = avs_writedata & be_mask;
  wire logic       mapped    = is_prio || hit(avs_address, `VIPC_OFS_FLAG0) ||
                               hit(avs_address, `VIPC_OFS_ENABLE0) ||
                               hit(avs_address, `VIPC_OFS_VECTOR) ||
                               hit(avs_address, `VIPC_OFS_STATUS) ||
                               hit(avs_address, `VIPC_OFS_MASK) ||
                               hit(avs_address, `VIPC_OFS_VSPACE);

  ////////////////////////////////////////////////////////////////////////////
  // Priority register bank
  vipc_prio_mem #(.NREG(NREG)) u_prio (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (wr_go && is_prio),
    .addr     (prio_ofs[$clog2(NREG)+1:2]),
    .wdata    (avs_writedata),
    .be       (avs_byteenable),
    .rdata_r  (prio_rdata),
    .flat     (prio_flat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-source decode of priority and subpriority
  logic [NSRC*5-1:0] levels;
  wire logic [NSRC-1:0] persist = NSRC'(`VIPC_PERSIST_MASK);
  logic [NSRC-1:0] active;
  genvar s;
  generate
    for (s = 0; s < NSRC; s++) begin : g_src
      wire logic [31:0] pr  = prio_flat[(s/4)*32 +: 32];
      wire logic [2:0]  pl  = pr[(s%4)*`VIPC_GRP_STRIDE + `VIPC_GRP_PRIO_LSB +: 3];
      wire logic [1:0]  sl  = pr[(s%4)*`VIPC_GRP_STRIDE + `VIPC_GRP_SUB_LSB +: 2];
      assign levels[s*5 +: 5] = {pl, sl};
      assign active[s] = flag_r[s] && enable_r[s] && pl != 3'b000;
    end
  endgenerate

  vipc_req_t win;
  logic      win_valid;
  vipc_arbiter #(.NSRC(NSRC)) u_arb (
    .active    (active),
    .levels    (levels),
    .win       (win),
    .win_valid (win_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag register: events set, write-one clears, set wins over clear
  wire logic [NSRC-1:0] flag_clr = (wr_go && hit(avs_address, `VIPC_OFS_FLAG0)) ?
                                   wd[NSRC-1:0] : '0;
  // Previous event level, idle low like the source lines
  logic [NSRC-1:0] src_prev_r;
  // Persistent sources set on level, the others on a rising edge only
  wire logic [NSRC-1:0] flag_set = src_event & (persist | ~src_prev_r);
  // Persistent sources re-set every cycle their condition is held
  wire logic [NSRC-1:0] flag_nxt = (flag_r & ~flag_clr) | flag_set;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r     <= '0;
      src_prev_r <= '0;
    end else begin
      flag_r     <= flag_nxt;
      src_prev_r <= src_event;
    end
  end

  // Enable register and vector spacing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_r <= '0;
      vspace_r <= `VIPC_VSPACE_RESET;
    end else if (wr_go) begin
      if (hit(avs_address, `VIPC_OFS_ENABLE0)) begin
        enable_r <= (enable_r & ~be_mask[NSRC-1:0]) | wd[NSRC-1:0];
      end
      if (hit(avs_address, `VIPC_OFS_VSPACE)) begin
        vspace_r <= (vspace_r & ~be_mask[15:0]) | wd[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: new winner and winner replaced by a different vector
  wire logic       new_req  = win_valid && !irq_req_r;
  wire logic       preempt  = win_valid && irq_req_r && win.vec != irq_vector_r;
  wire logic [1:0] ev_set   = {preempt, new_req};
  wire logic [1:0] st_clr   = (wr_go && hit(avs_address, `VIPC_OFS_STATUS)) ? wd[1:0] : 2'b00;
  wire logic [1:0] status_nxt = (status_r & ~st_clr) | ev_set;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_r <= 2'b00;
      mask_r   <= 2'b00;
      irq_out_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_go && hit(avs_address, `VIPC_OFS_MASK)) begin
        mask_r <= wd[1:0];
      end
      irq_out_r <= |(status_nxt & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core request outputs, vector spacing from the writable spacing register
  wire logic [31:0] entry = 32'(vspace_r) * 32'(win.vec);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_req_r    <= 1'b0;
      irq_vector_r <= 5'h00;
      irq_level_r  <= 3'h0;
      irq_entry_r  <= 32'h00000000;
    end else begin
      irq_req_r    <= win_valid;
      irq_vector_r <= win_valid ? win.vec : 5'h00;
      irq_level_r  <= win_valid ? win.prio : 3'h0;
      irq_entry_r  <= win_valid ? entry : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: writes done in one cycle, reads take two
  wire logic [31:0] rd_mux =
    hit(avs_address, `VIPC_OFS_FLAG0)   ? 32'(flag_r) :
    hit(avs_address, `VIPC_OFS_ENABLE0) ? 32'(enable_r) :
    hit(avs_address, `VIPC_OFS_VECTOR)  ? {24'h0, irq_req_r, 2'b00, irq_vector_r} :
    hit(avs_address, `VIPC_OFS_STATUS)  ? {30'h0, status_r} :
    hit(avs_address, `VIPC_OFS_MASK)    ? {30'h0, mask_r} :
    hit(avs_address, `VIPC_OFS_VSPACE)  ? {16'h0, vspace_r} : 32'h00000000;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_st_r     <= VIPC_S_IDLE;
      rd_mux_r     <= 32'h0;
      rd_prio_r    <= 1'b0;
      avs_response <= 2'b00;
    end else begin
      unique case (bus_st_r)
        VIPC_S_IDLE: begin
          if (rd_go) begin
            bus_st_r     <= VIPC_S_READ;
            rd_mux_r     <= rd_mux;
            rd_prio_r    <= is_prio;
            avs_response <= mapped ? 2'b00 : 2'b10;
          end
        end
        VIPC_S_READ: begin
          bus_st_r <= VIPC_S_IDLE;
        end
        default: bus_st_r <= VIPC_S_IDLE;
      endcase
    end
  end
  always_comb begin
    avs_waitrequest = avs_read && bus_st_r == VIPC_S_IDLE;
    avs_readdata    = rd_prio_r ? prio_rdata : rd_mux_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_zero_prio_idle: assert property (@(posedge core_clk) disable iff (rst)
    irq_req_r |-> irq_level_r != 3'h0) else $error("request at level zero");
  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (rst)
    $rose(src_event[0]) |=> flag_r[0]) else $error("event lost");
  a_persist_hold: assert property (@(posedge core_clk) disable iff (rst)
    src_event[16] [*2] |-> flag_r[16]) else $error("persistent flag dropped");
  a_entry_spacing: assert property (@(posedge core_clk) disable iff (rst)
    irq_req_r |-> irq_entry_r == 32'($past(vspace_r)) * 32'(irq_vector_r))
    else $error("entry not spacing times vector");
  a_prio_unused: assert property (@(posedge core_clk) disable iff (rst)
    (prio_flat[31:0] & ~`VIPC_PRIO_MASK) == 32'h0) else $error("unused bits stored");
  a_win_enabled: assert property (@(posedge core_clk) disable iff (rst)
    irq_req_r |-> 1'($past(active) >> irq_vector_r))
    else $error("winner not pending and enabled");
  a_win_highest: assert property (@(posedge core_clk) disable iff (rst)
    win_valid && active[0] |-> win.prio >= levels[4:2]) else $error("lower priority won");
  a_sub_order: assert property (@(posedge core_clk) disable iff (rst)
    win_valid && active[1] && levels[9:7] == win.prio |-> win.sub >= levels[6:5])
    else $error("lower subpriority won");
  a_read_answer: assert property (@(posedge core_clk) disable iff (rst)
    rd_go |=> !avs_waitrequest) else $error("read not answered in two cycles");
  c_request: cover property (@(posedge core_clk) disable iff (rst) $rose(irq_req_r));
  c_preempt: cover property (@(posedge core_clk) disable iff (rst) preempt);
  c_irq_out: cover property (@(posedge core_clk) disable iff (rst) $rose(irq_out_r));
  c_persist_clr: cover property (@(posedge core_clk) disable iff (rst)
    flag_clr[16] && src_event[16]);
endmodule : vipc_top

// ===== hdl/vipc_regs.svh
// Register map and field constants of the vectored interrupt controller.
// Assumes inclusion by bare name from design files.
`ifndef VIPC_REGS_SVH
`define VIPC_REGS_SVH
`define VIPC_NUM_SRC        23
`define VIPC_NUM_PRIO_REGS  6
`define VIPC_OFS_FLAG0      8'h00
`define VIPC_OFS_ENABLE0    8'h04
`define VIPC_OFS_PRIO_BASE  8'h10
`define VIPC_OFS_VECTOR     8'h30
`define VIPC_OFS_STATUS     8'h34
`define VIPC_OFS_MASK       8'h38
`define VIPC_OFS_VSPACE     8'h3C
`define VIPC_PRIO_MASK      32'h1F1F1F1F
`define VIPC_PERSIST_MASK   23'h730000
`define VIPC_RESET_VALUE    32'h00000000
`define VIPC_VSPACE_RESET   16'h0020
`define VIPC_GRP_PRIO_LSB   2
`define VIPC_GRP_SUB_LSB    0
`define VIPC_GRP_STRIDE     8
`endif

// ===== hdl/vipc_pkg.sv
// Types shared by the vectored interrupt controller files.
// Assumes vipc_regs.svh constants.
package vipc_pkg;
  // Decoded request of one source
  typedef struct packed {
    logic [2:0] prio;
    logic [1:0] sub;
    logic [4:0] vec;
  } vipc_req_t;
  // Status register event bits
  typedef enum logic [1:0] {
    VIPC_EV_NEW  = 2'b00,
    VIPC_EV_LOST = 2'b01
  } vipc_ev_t;
  typedef enum logic [1:0] {
    VIPC_S_IDLE = 2'b00,
    VIPC_S_READ = 2'b01
  } vipc_bus_state_t;
endpackage : vipc_pkg

// ===== hdl/vipc_arbiter.sv
// Priority arbiter: picks the highest request among all sources.
// Assumes inputs come from the same clock domain.
`timescale 1ns/1ns
`include "vipc_regs.svh"
module vipc_arbiter
  import vipc_pkg::*;
#(
  parameter int NSRC = `VIPC_NUM_SRC
) (
  // Per-source requests
  input  wire logic [NSRC-1:0]    active,
  input  wire logic [NSRC*5-1:0]  levels,
  // Winner
  output vipc_req_t               win,
  output logic                    win_valid
);
  vipc_req_t cand [NSRC+1];
  logic      vld  [NSRC+1];
  // Vector field is five bits wide
  if (NSRC < 1 || NSRC > 32) begin : g_bad_cfg
    $error("vipc_arbiter: unsupported source count");
  end
  assign cand[0] = '0;
  assign vld[0]  = 1'b0;
  // Linear scan; strict greater keeps lower vector on full ties
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_scan
      wire logic [4:0] lv = levels[g*5 +: 5];
      wire logic beats = active[g] &&
        (!vld[g] || lv > {cand[g].prio, cand[g].sub});
      assign cand[g+1] = beats ?
        vipc_req_t'{prio: lv[4:2], sub: lv[1:0], vec: 5'(g)} : cand[g];
      assign vld[g+1]  = vld[g] | beats;
    end
  endgenerate
  assign win       = cand[NSRC];
  assign win_valid = vld[NSRC];
endmodule : vipc_arbiter

// ===== hdl/vipc_prio_mem.sv
// Priority-control register bank with registered read data.
// Assumes single clock and asynchronous active-high reset.
`timescale 1ns/1ns
`include "vipc_regs.svh"
module vipc_prio_mem #(
  parameter int NREG = `VIPC_NUM_PRIO_REGS
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // Write and read port
  input  wire logic                    wr_en,
  input  wire logic [$clog2(NREG)-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              be,
  output logic [31:0]                  rdata_r,
  // All registers flat for decoding
  output logic [NREG*32-1:0]           flat
);
  logic [31:0] mem_r [NREG];
  // Address port needs at least one bit
  if (NREG < 2) begin : g_bad_cfg
    $error("vipc_prio_mem: unsupported register count");
  end
  genvar i;
  generate
    for (i = 0; i < NREG; i++) begin : g_reg
      assign flat[i*32 +: 32] = mem_r[i];
      // Unused bits never store, so they read zero
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          mem_r[i] <= `VIPC_RESET_VALUE;
        end else if (wr_en && addr == i) begin
          for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
              mem_r[i][b*8 +: 8] <= wdata[b*8 +: 8] & 8'h1F;
            end
          end
        end
      end
    end
  endgenerate
  // Registered read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= (addr < NREG) ? mem_r[addr] : 32'h0;
    end
  end
endmodule : vipc_prio_mem

// ===== verification/vipc_core_model.sv
// Far-side model: the sources feeding the controller.
// Assumes core_clk domain; bench gives pulses and held conditions.
`timescale 1ns/1ns
`include "vipc_regs.svh"
module vipc_core_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Bench control
  input  wire logic [22:0] fire,
  input  wire logic [22:0] hold,
  // Controller side
  output logic [22:0]      src_event
);
  // Pulses pass once; conditions only on persistent sources
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      src_event <= '0;
    else
      src_event <= fire | (hold & `VIPC_PERSIST_MASK);
  end
endmodule : vipc_core_model

// ===== verification/vipc_top_tb.sv
// Bench of the interrupt controller: table of arbitration cases, then edge cases.
// Assumes vipc_top, vipc_core_model and vipc_regs.svh.
`timescale 1ns/1ns
module vipc_top_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] pv;
    logic [22:0] m;
    logic        req;
    logic [2:0]  lvl;
    logic [4:0]  vec;
  } vipc_row_t;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, irq_entry_r, rd;
  logic        avs_waitrequest, irq_req_r, irq_out_r;
  logic [1:0]  avs_response, rsp;
  logic [22:0] src_event, fire = '0, hold = '0;
  logic [4:0]  irq_vector_r;
  logic [2:0]  irq_level_r;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                           8'h34, 8'h38};
  vipc_row_t   rows [8] = '{
    '{8'h10, 32'h1F1F1F1F, 23'h000009, 1'b1, 3'h7, 5'h00},
    '{8'h14, 32'h1F1F1F1E, 23'h000030, 1'b1, 3'h7, 5'h05},
    '{8'h14, 32'h0A040000, 23'h000010, 1'b0, 3'h0, 5'h00},
    '{8'h14, 32'h0A040000, 23'h0000D0, 1'b1, 3'h2, 5'h07},
    '{8'h14, 32'h0A040000, 23'h000040, 1'b1, 3'h1, 5'h06},
    '{8'h24, 32'h00041F08, 23'h500000, 1'b1, 3'h2, 5'h14},
    '{8'h24, 32'h00041F08, 23'h700000, 1'b1, 3'h7, 5'h15},
    '{8'h10, 32'h1F1F1F1F, 23'h400008, 1'b1, 3'h7, 5'h03}};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #25 core_clk = ~core_clk;
  vipc_top DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .src_event(src_event), .irq_req_r(irq_req_r), .irq_vector_r(irq_vector_r),
    .irq_level_r(irq_level_r), .irq_entry_r(irq_entry_r), .irq_out_r(irq_out_r));
  vipc_core_model SRC (.core_clk(core_clk), .rst(rst), .fire(fire), .hold(hold),
    .src_event(src_event));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_core(input logic [40:0] got, input logic [40:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_core
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd  = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      results();
    end
  endtask : bus
  // One-cycle source pulse, then settle
  task automatic pulse(input logic [22:0] m);
    @(posedge core_clk);
    fire <= m;
    @(posedge core_clk);
    fire <= '0;
    repeat (4) @(posedge core_clk);
  endtask : pulse
  task automatic results();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    bus(1, 8'h04, 32'h007FFFFF, 4'hF);
    bus(1, 8'h3C, 32'h00000040, 4'hF);
    foreach (rows[i]) begin
      bus(1, 8'h00, 32'h007FFFFF, 4'hF);
      bus(1, rows[i].a, rows[i].pv, 4'hF);
      pulse(rows[i].m);
      chk_core({irq_req_r, irq_level_r, irq_vector_r, irq_entry_r}, {rows[i].req,
        rows[i].lvl, rows[i].vec, 32'(rows[i].vec) * 32'h40});
      bus(0, 8'h30, 32'h0, 4'hF);
      chk_reg(rd, {24'h0, rows[i].req, 2'b00, rows[i].vec});
      bus(0, 8'h00, 32'h0, 4'hF);
      chk_reg(rd, {9'h0, rows[i].m});
    end
    // Disabled source stays silent
    bus(1, 8'h04, 32'h007FFFF7, 4'hF);
    bus(1, 8'h00, 32'h007FFFFF, 4'hF);
    pulse(23'h000008);
    chk_core({irq_req_r, irq_level_r, irq_vector_r, irq_entry_r}, 41'h0);
    bus(1, 8'h00, 32'h007FFFFF, 4'hF);
    bus(1, 8'h04, 32'h007FFFFF, 4'hF);
    // Held condition re-sets its flag after a clear
    hold <= 23'h020000;
    bus(1, 8'h00, 32'h00020000, 4'hF);
    bus(0, 8'h00, 32'h0, 4'hF);
    chk_reg(rd, 32'h00020000);
    hold <= '0;
    bus(1, 8'h00, 32'h007FFFFF, 4'hF);
    bus(0, 8'h00, 32'h0, 4'hF);
    chk_reg(rd, 32'h00000000);
    // Held level on a non-persistent source sets its flag only once
    fire <= 23'h000008;
    bus(1, 8'h00, 32'h007FFFFF, 4'hF);
    bus(1, 8'h00, 32'h00000008, 4'hF);
    bus(0, 8'h00, 32'h0, 4'hF);
    chk_reg(rd, 32'h00000000);
    fire <= '0;
    // Status, mask and interrupt line
    bus(1, 8'h38, 32'h00000001, 4'hF);
    bus(1, 8'h34, 32'h00000003, 4'hF);
    bus(0, 8'h34, 32'h0, 4'hF);
    chk_reg(rd, 32'h00000000);
    chk_core(41'(irq_out_r), 41'h0);
    pulse(23'h000008);
    chk_core(41'(irq_out_r), 41'h1);
    bus(1, 8'h38, 32'h00000000, 4'hF);
    bus(0, 8'h34, 32'h0, 4'hF);
    chk_reg(rd & 32'h1, 32'h1);
    chk_core(41'(irq_out_r), 41'h0);
    bus(1, 8'h38, 32'h00000001, 4'hF);
    bus(1, 8'h34, 32'h00000003, 4'hF);
    bus(0, 8'h00, 32'h0, 4'hF);
    chk_core(41'(irq_out_r), 41'h0);
    // Lower vector at equal level takes over: winner-changed bit only
    pulse(23'h000001);
    bus(0, 8'h34, 32'h0, 4'hF);
    chk_reg(rd, 32'h00000002);
    chk_core(41'(irq_out_r), 41'h0);
    // Unmapped read answers with an error
    bus(0, 8'h40, 32'h0, 4'hF);
    chk_reg(rd, 32'h0);
    chk_reg(32'(rsp), 32'h2);
    // Second reset in mid-run, then reset values
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    chk_core({irq_req_r, irq_level_r, irq_vector_r, irq_entry_r}, 41'h0);
    foreach (ra[k]) begin
      bus(0, ra[k], 32'h0, 4'hF);
      chk_reg(rd, 32'h0);
    end
    bus(0, 8'h3C, 32'h0, 4'hF);
    chk_reg(rd, 32'h00000020);
    // Unused priority bits and lane masking
    bus(1, 8'h18, 32'hFFFFFFFF, 4'hF);
    bus(0, 8'h18, 32'h0, 4'hF);
    chk_reg(rd, 32'h1F1F1F1F);
    bus(1, 8'h18, 32'h00000000, 4'h1);
    bus(0, 8'h18, 32'h0, 4'hF);
    chk_reg(rd, 32'h1F1F1F00);
    results();
  end
endmodule : vipc_top_tb
